// ===== bie_defines.svh
// Opcode fields, widths and reset values for the branch and increment execute block
//
// Contract
// - Memory increment writes sum to memory and accumulator
// - Taken jump replaces program counter bits ten..zero
// - Accumulator bit zero set: jump, else increment
// - Accumulator bit one set: jump, else increment
// - Accumulator bit two set: jump, else increment
// - Accumulator bit three set: jump, else increment
// - Carry set: jump, else increment
// - Absolute jump always loads target
// - Carry clear: jump, else increment
// - Accumulator nonzero: jump, else increment
// - Accumulator zero: jump, else increment
`ifndef BIE_DEFINES_SVH
`define BIE_DEFINES_SVH
`define BIE_INC_PREFIX 9'h094
`define BIE_INC_PREFIX_MSB 15
`define BIE_INC_PREFIX_LSB 7
`define BIE_JMP_PREFIX_MSB 15
`define BIE_JMP_PREFIX_LSB 11
`define BIE_JB0_PREFIX 5'h10
`define BIE_JB1_PREFIX 5'h12
`define BIE_JB2_PREFIX 5'h14
`define BIE_JB3_PREFIX 5'h16
`define BIE_JC_PREFIX 5'h1e
`define BIE_JMP_PREFIX 5'h0e
`define BIE_JNC_PREFIX 5'h1a
`define BIE_JNZ_PREFIX 5'h18
`define BIE_JZ_PREFIX 5'h1c
`define BIE_PC_RESET 11'h000
`define BIE_ACC_RESET 4'h0
`define BIE_CARRY_RESET 1'h0
`define BIE_ZERO_RESET 1'h0
`define BIE_WR_EN_RESET 1'h0
`define BIE_WR_ADDR_RESET 7'h00
`define BIE_WR_DATA_RESET 4'h0
`define BIE_TARGET_MSB 10
`define BIE_TARGET_LSB 0
`define BIE_ADDR_MSB 6
`define BIE_ADDR_LSB 0
`endif

// ===== bie_pkg.sv
// Types shared by the branch and increment execute block
package bie_pkg;
   typedef enum logic [3:0] {
      BIE_OP_NONE = 4'h0,
      BIE_OP_INC = 4'h1,
      BIE_OP_JB0 = 4'h2,
      BIE_OP_JB1 = 4'h3,
      BIE_OP_JB2 = 4'h4,
      BIE_OP_JB3 = 4'h5,
      BIE_OP_JC = 4'h6,
      BIE_OP_JMP = 4'h7,
      BIE_OP_JNC = 4'h8,
      BIE_OP_JNZ = 4'h9,
      BIE_OP_JZ = 4'ha
   } bie_op_t;

   typedef struct packed {
      logic wrEn;
      logic [6:0] addr;
      logic [3:0] data;
   } bie_mem_wr_t;

   typedef struct packed {
      logic carry;
      logic zero;
   } bie_flags_t;
endpackage

// ===== bie_decode.sv
// Instruction word decoder for the branch and increment group
`include "bie_defines.svh"
module bie_decode
   import bie_pkg::*;
(
   input wire logic [15:0] instr, // Instruction word
   output bie_op_t op, // Decoded operation
   output logic [10:0] target, // Jump target field
   output logic [6:0] memAddr // Data memory address field
);
   logic [4:0] jmpField;
   logic [8:0] incField;

   assign jmpField = instr[`BIE_JMP_PREFIX_MSB:`BIE_JMP_PREFIX_LSB];
   assign incField = instr[`BIE_INC_PREFIX_MSB:`BIE_INC_PREFIX_LSB];
   assign target = instr[`BIE_TARGET_MSB:`BIE_TARGET_LSB];
   assign memAddr = instr[`BIE_ADDR_MSB:`BIE_ADDR_LSB];

   always_comb begin
      op = BIE_OP_NONE;
      if (incField == `BIE_INC_PREFIX) begin
         op = BIE_OP_INC;
      end else begin
         case (jmpField)
            `BIE_JB0_PREFIX: op = BIE_OP_JB0;
            `BIE_JB1_PREFIX: op = BIE_OP_JB1;
            `BIE_JB2_PREFIX: op = BIE_OP_JB2;
            `BIE_JB3_PREFIX: op = BIE_OP_JB3;
            `BIE_JC_PREFIX: op = BIE_OP_JC;
            `BIE_JMP_PREFIX: op = BIE_OP_JMP;
            `BIE_JNC_PREFIX: op = BIE_OP_JNC;
            `BIE_JNZ_PREFIX: op = BIE_OP_JNZ;
            `BIE_JZ_PREFIX: op = BIE_OP_JZ;
            default: op = BIE_OP_NONE;
         endcase
      end
   end
endmodule

// ===== bie_exec.sv
// Execute stage for memory increment and the jump family
`include "bie_defines.svh"
module bie_exec
   import bie_pkg::*;
#(
   parameter int PC_W = 11
)
(
   input wire logic sys_clk, // Core clock
   input wire logic rst_b, // Asynchronous reset, active low
   input wire logic instrValid, // Instruction word present this cycle
   input wire logic [15:0] instr, // Instruction word from program memory
   output logic [6:0] memRdAddr, // Data memory read address
   input wire logic [3:0] memRdData, // Data memory read data, same cycle
   output bie_mem_wr_t memWr, // Data memory write, registered
   output logic [3:0] accumulator, // Accumulator
   output bie_flags_t flags, // Carry and zero flags
   output logic [PC_W-1:0] programCounter, // Program counter
   output logic handled // Instruction belongs to this group
);
   // ==========================================================
   // Decoded operation and fields
   bie_op_t op;
   logic [10:0] target;
   logic isInc;
   logic isAbsJump;
   logic isBitJump;
   logic isCarryJump;
   logic isNoCarryJump;
   logic isZeroJump;
   logic isNonZeroJump;
   logic [1:0] bitSel;

   // ==========================================================
   // Condition sources and next values
   logic accBitSet;
   logic accIsZero;
   logic takeJump;
   logic [4:0] incSum;
   logic [3:0] incResult;
   logic incWrap;
   logic [PC_W-1:0] pcInc;
   logic [PC_W-1:0] pcJump;
   logic [PC_W-1:0] pc_q;
   logic [PC_W-1:0] pc_d;
   logic [3:0] acc_q;
   logic [3:0] acc_d;
   logic carry_q;
   logic carry_d;
   logic zero_q;
   logic zero_d;
   logic wrEn_q;
   logic wrEn_d;
   logic [6:0] wrAddr_q;
   logic [6:0] wrAddr_d;
   logic [3:0] wrData_q;
   logic [3:0] wrData_d;

   // ==========================================================
   // Decode
   bie_decode bie_decode_i (
      .instr(instr),
      .op(op),
      .target(target),
      .memAddr(memRdAddr)
   );

   // Non-group words leave every register untouched except the write strobe, which clears
   assign handled = instrValid && (op != BIE_OP_NONE);
   assign isInc = handled && (op == BIE_OP_INC);

   // ==========================================================
   // Jump class
   always_comb begin
      isAbsJump = 1'b0;
      isBitJump = 1'b0;
      isCarryJump = 1'b0;
      isNoCarryJump = 1'b0;
      isZeroJump = 1'b0;
      isNonZeroJump = 1'b0;
      bitSel = 2'h0;
      case (op)
         BIE_OP_JB0: begin
            isBitJump = 1'b1;
            bitSel = 2'h0;
         end
         BIE_OP_JB1: begin
            isBitJump = 1'b1;
            bitSel = 2'h1;
         end
         BIE_OP_JB2: begin
            isBitJump = 1'b1;
            bitSel = 2'h2;
         end
         BIE_OP_JB3: begin
            isBitJump = 1'b1;
            bitSel = 2'h3;
         end
         BIE_OP_JC: begin
            isCarryJump = 1'b1;
         end
         BIE_OP_JMP: begin
            isAbsJump = 1'b1;
         end
         BIE_OP_JNC: begin
            isNoCarryJump = 1'b1;
         end
         BIE_OP_JNZ: begin
            isNonZeroJump = 1'b1;
         end
         BIE_OP_JZ: begin
            isZeroJump = 1'b1;
         end
         default: begin
            isAbsJump = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // Branch condition
   // Reads the registered accumulator and carry flag, as the previous
   // instruction left them
   assign accBitSet = acc_q[bitSel];
   assign accIsZero = (acc_q == 4'h0);

   always_comb begin
      takeJump = 1'b0;
      if (isAbsJump) begin
         takeJump = 1'b1;
      end else if (isBitJump) begin
         takeJump = accBitSet;
      end else if (isCarryJump) begin
         takeJump = carry_q;
      end else if (isNoCarryJump) begin
         takeJump = !carry_q;
      end else if (isNonZeroJump) begin
         takeJump = !accIsZero;
      end else if (isZeroJump) begin
         takeJump = accIsZero;
      end
   end

   // ==========================================================
   // Program counter next value
   // Bits above ten survive a jump, so a wider counter stays in its page
   assign pcInc = pc_q + PC_W'(1'h1);

   always_comb begin
      pcJump = pc_q;
      pcJump[`BIE_TARGET_MSB:`BIE_TARGET_LSB] = target;
   end

   always_comb begin
      pc_d = pc_q;
      if (handled) begin
         if (takeJump) begin
            pc_d = pcJump;
         end else begin
            pc_d = pcInc;
         end
      end
   end

   // ==========================================================
   // Increment arithmetic
   // One spare adder bit catches the wrap from fifteen to zero
   assign incSum = {1'b0, memRdData} + 5'h01;
   assign incResult = incSum[3:0];
   assign incWrap = incSum[4];

   always_comb begin
      acc_d = acc_q;
      carry_d = carry_q;
      zero_d = zero_q;
      if (isInc) begin
         acc_d = incResult;
         carry_d = incWrap;
         zero_d = (incResult == 4'h0);
      end
   end

   // Write-back address and data hold between increments to save toggling; the strobe clears
   always_comb begin
      wrEn_d = isInc;
      wrAddr_d = wrAddr_q;
      wrData_d = wrData_q;
      if (isInc) begin
         wrAddr_d = memRdAddr;
         wrData_d = incResult;
      end
   end

   // ==========================================================
   // Program counter register
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pc_q <= PC_W'(`BIE_PC_RESET);
      end else begin
         pc_q <= pc_d;
      end
   end

   // ==========================================================
   // Accumulator register
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         acc_q <= `BIE_ACC_RESET;
      end else begin
         acc_q <= acc_d;
      end
   end

   // ==========================================================
   // Carry flag register
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         carry_q <= `BIE_CARRY_RESET;
      end else begin
         carry_q <= carry_d;
      end
   end

   // ==========================================================
   // Zero flag register
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         zero_q <= `BIE_ZERO_RESET;
      end else begin
         zero_q <= zero_d;
      end
   end

   // ==========================================================
   // Data memory write-back, strobe on the same edge that updates the accumulator
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wrEn_q <= `BIE_WR_EN_RESET;
         wrAddr_q <= `BIE_WR_ADDR_RESET;
         wrData_q <= `BIE_WR_DATA_RESET;
      end else begin
         wrEn_q <= wrEn_d;
         wrAddr_q <= wrAddr_d;
         wrData_q <= wrData_d;
      end
   end

   // ==========================================================
   // Outputs
   assign accumulator = acc_q;
   assign flags = {carry_q, zero_q};
   assign programCounter = pc_q;
   assign memWr = {wrEn_q, wrAddr_q, wrData_q};
endmodule

// ===== bie_exec_assertions.sv
// Checker for the branch and increment execute block
module bie_exec_assertions
   import bie_pkg::*;
#(parameter int PC_W = 11)
(
   input wire logic sys_clk, // Clock
   input wire logic rst_b, // Reset
   input wire logic [15:0] instr, // Word
   input wire logic [3:0] memRdData, // Read data
   input wire bie_mem_wr_t memWr, // Write
   input wire logic [3:0] accumulator, // Accumulator
   input wire bie_flags_t flags, // Flags
   input wire logic [PC_W-1:0] programCounter, // Counter
   input wire logic handled // In group
);
   logic tk;
   logic bitOp;
   logic [10:0] nxt;
   // ============================================
   // Expected counter one edge ahead
   always_comb begin
      case (instr[15:11])
         5'h0e: tk = 1'b1;
         5'h1e: tk = flags.carry;
         5'h1a: tk = !flags.carry;
         5'h18: tk = |accumulator;
         5'h1c: tk = ~|accumulator;
         default: tk = accumulator[instr[13:12]];
      endcase
      nxt = tk ? instr[10:0] : programCounter[10:0] + 11'h1;
   end
   assign bitOp = handled && instr[15:14] == 2'b10 && !instr[11];
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   sequence incS;
      handled && instr[15:7] == 9'h094;
   endsequence
   property pcP(c);
      c |=> programCounter[10:0] == $past(nxt);
   endproperty
   // ============================================
   // Properties
   inc_write_a: assert property (incS |=> memWr.wrEn && memWr.addr == $past(instr[6:0])
      && memWr.data == accumulator && accumulator == $past(memRdData) + 4'h1)
      else $error("increment result wrong");
   inc_flags_a: assert property (incS |=> flags == {$past(memRdData) == 4'hf,
      4'($past(memRdData) + 4'h1) == 4'h0}) else $error("increment flags wrong");
   bit_jump_a: assert property (pcP(bitOp))
      else $error("bit jump wrong");
   abs_jump_a: assert property (pcP(handled && instr[15:11] == 5'h0e))
      else $error("absolute jump wrong");
   carry_jump_a: assert property (pcP(handled && instr[15:11] == 5'h1e))
      else $error("carry jump wrong");
   nocarry_jump_a: assert property (pcP(handled && instr[15:11] == 5'h1a))
      else $error("no carry jump wrong");
   nz_jump_a: assert property (pcP(handled && instr[15:11] == 5'h18))
      else $error("nonzero jump wrong");
   z_jump_a: assert property (pcP(handled && instr[15:11] == 5'h1c))
      else $error("zero jump wrong");
   idle_hold_a: assert property (!handled |=> $stable(programCounter)
      && $stable(accumulator) && $stable(flags) && !memWr.wrEn)
      else $error("idle word changed state");
   jump_keeps_a: assert property (handled && instr[15:7] != 9'h094
      |=> $stable(accumulator) && $stable(flags) && !memWr.wrEn)
      else $error("jump changed accumulator or flags");
endmodule
bind bie_exec bie_exec_assertions #(.PC_W(PC_W)) bie_exec_assertions_i (.sys_clk(sys_clk),
   .rst_b(rst_b), .instr(instr), .memRdData(memRdData), .memWr(memWr), .flags(flags),
   .accumulator(accumulator), .programCounter(programCounter), .handled(handled));

// ===== tb_bie_exec.sv
// Testbench for the branch and increment execute block
module tb_bie_exec
   import bie_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic instrValid = 1'b0;
   logic [15:0] instr = 16'h0000;
   logic [3:0] memRdData = 4'h0;
   logic [3:0] accumulator;
   logic [6:0] memRdAddr;
   bie_mem_wr_t memWr;
   bie_flags_t flags;
   logic [10:0] programCounter;
   logic [10:0] epc = 11'h000;
   logic handled;
   int mismatches = 0;
   int checks = 0;
   bie_exec bie_exec_i (.sys_clk(sys_clk), .rst_b(rst_b), .instrValid(instrValid),
      .instr(instr), .memRdAddr(memRdAddr), .memRdData(memRdData), .memWr(memWr),
      .accumulator(accumulator), .flags(flags), .programCounter(programCounter),
      .handled(handled));
   always #25 sys_clk = ~sys_clk;
   task chk(string n, logic [15:0] e, logic [15:0] g);
      checks++;
      if (e !== g) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task exe(logic [15:0] w, logic [3:0] d);
      logic hExp;
      hExp = (w[15:7] == 9'h094) || (w[15:11] inside {5'h10, 5'h12, 5'h14, 5'h16, 5'h1e,
         5'h0e, 5'h1a, 5'h18, 5'h1c});
      @(posedge sys_clk);
      instr <= w;
      memRdData <= d;
      instrValid <= 1'b1;
      @(negedge sys_clk);
      chk("handled", {15'h0000, hExp}, {15'h0000, handled});
      chk("memRdAddr", {9'h000, w[6:0]}, {9'h000, memRdAddr});
      @(posedge sys_clk);
      instrValid <= 1'b0;
      @(negedge sys_clk);
   endtask
   task jmp(logic [15:0] w, logic t);
      exe(w, 4'h3);
      epc = t ? w[10:0] : epc + 11'h1;
      chk("pc", {5'h00, epc}, {5'h00, programCounter});
   endtask
   task t_inc;
      chk("pc", 16'h0000, {5'h00, programCounter});
      exe({9'h094, 7'h55}, 4'hf);
      chk("acc", 16'h0000, {12'h000, accumulator});
      chk("flags", 16'h0003, {14'h0000, flags});
      chk("wr", 16'h0d50, {4'h0, memWr});
      chk("pc", 16'h0001, {5'h00, programCounter});
      exe({9'h094, 7'h2a}, 4'h6);
      chk("acc", 16'h0007, {12'h000, accumulator});
      chk("flags", 16'h0000, {14'h0000, flags});
      chk("wr", 16'h0aa7, {4'h0, memWr});
      exe(16'h8800, 4'h1);
      chk("wrEn", 16'h0000, {15'h0000, memWr.wrEn});
      chk("pc", 16'h0002, {5'h00, programCounter});
      $display("t_inc done");
   endtask
   task t_bits;
      logic [3:0] a;
      a = 4'h5;
      repeat (2) begin
         exe({9'h094, 7'h12}, a - 4'h1);
         jmp({5'h0e, 11'h7ff}, 1'b1);
         for (int i = 0; i < 4; i++) begin
            jmp({2'b10,2'(i),1'b0,2'(i),9'h155}, a[i]);
         end
         a = 4'ha;
      end
      $display("t_bits done");
   endtask
   task t_flags;
      logic [4:0] ops [4];
      ops = '{5'h1e, 5'h1c, 5'h1a, 5'h18};
      for (int s = 0; s < 2; s++) begin
         exe({9'h094, 7'h7f}, s ? 4'hf : 4'h2);
         chk("flags", s ? 16'h0003 : 16'h0000, {14'h0000, flags});
         jmp({5'h0e, 11'h2aa}, 1'b1);
         for (int k = 0; k < 4; k++) begin
            jmp({ops[k], 11'h155}, (k < 2) == (s == 1));
         end
      end
      $display("t_flags done");
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_inc;
      t_bits;
      t_flags;
      end_of_test;
   end
   // Run needs about 70 cycles
   initial begin
      #50000;
      mismatches++;
      end_of_test;
   end
endmodule
